// ---- slsq_pkg.sv ----
// Purpose: shared constants and types of the status indicator sequencer
// Assumes: 20 MHz aclk, 8-bit AXI4-Lite byte addresses
// Notes:   all offsets are byte addresses of aligned 32-bit words
package slsq_pkg;

  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int NUM_PORTS = 6;
  localparam int NUM_LEDS  = 2 * NUM_PORTS + 2;
  localparam int LED_HEALTH = 2 * NUM_PORTS;
  localparam int LED_RING   = 2 * NUM_PORTS + 1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ       = 20_000_000;
  localparam int SEC_MS       = 1000;
  localparam int BLINK_MS     = 250;
  localparam int SEC_CYCLES   = CLK_HZ / 1000 * SEC_MS;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [6:0] LAMP_START_S = 7'h1e;
  localparam logic [6:0] LAMP_END_S   = 7'h28;
  localparam logic [6:0] FAIL_S       = 7'h3c;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STEP       = 8'h04;
  localparam logic [7:0] ADDR_RESULT     = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
  localparam logic [7:0] ADDR_PORT_BASE  = 8'h20;

  localparam int CTRL_NONFATAL  = 0;
  localparam int CTRL_RING_OK   = 1;
  localparam int RESULT_DONE    = 0;
  localparam int RESULT_FATAL   = 1;
  localparam int STATUS_STATE   = 0;
  localparam int STATUS_SEC     = 8;
  localparam int IRQ_PASS       = 0;
  localparam int IRQ_FAIL       = 1;
  localparam int IRQ_LAMP       = 2;
  localparam int PORT_MODE      = 0;
  localparam int PORT_UNIT      = 4;
  localparam int PORT_FAULT     = 8;

  localparam logic [1:0] CTRL_RESET     = 2'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF     = 3'h0,
    MODE_GREEN   = 3'h1,
    MODE_AMBER   = 3'h2,
    MODE_FLASH_G = 3'h3,
    MODE_FLASH_A = 3'h4,
    MODE_ALT     = 3'h5
  } slsq_mode_t;

  typedef enum logic [1:0] {
    UNIT_M  = 2'h0,
    UNIT_S  = 2'h1,
    UNIT_AB = 2'h2
  } slsq_unit_t;

  typedef enum logic [1:0] {
    ST_POWER = 2'h0,
    ST_TEST  = 2'h1,
    ST_RUN   = 2'h3,
    ST_FAIL  = 2'h2
  } slsq_state_t;

endpackage

// ---- slsq_led_if.sv ----
// Purpose: one bicolor indicator: requested mode and driven colors
// Assumes: mode and colors share aclk
// Notes:   src side chooses the mode, enc side drives the lamps
`timescale 1ns/1ns
interface slsq_led_if;
  slsq_pkg::slsq_mode_t mode;
  logic                 green;
  logic                 amber;
  modport src (output mode, input green, input amber);
  modport enc (input mode, output green, output amber);
endinterface

// ---- slsq_led_enc.sv ----
// Purpose: turns an indicator mode and the blink phase into lamp drives
// Assumes: phase toggles at the blink rate
// Notes:   colors are registered so top outputs come from flops
`timescale 1ns/1ns
module slsq_led_enc (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic phase,
  slsq_led_if.enc   led
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led.green <= 1'b0;
      led.amber <= 1'b0;
    end else begin
      unique case (led.mode)
        slsq_pkg::MODE_GREEN: begin
          led.green <= 1'b1;
          led.amber <= 1'b0;
        end
        slsq_pkg::MODE_AMBER: begin
          led.green <= 1'b0;
          led.amber <= 1'b1;
        end
        slsq_pkg::MODE_FLASH_G: begin
          led.green <= phase;
          led.amber <= 1'b0;
        end
        slsq_pkg::MODE_FLASH_A: begin
          led.green <= 1'b0;
          led.amber <= phase;
        end
        slsq_pkg::MODE_ALT: begin
          // never both colors at once
          led.green <= phase;
          led.amber <= ~phase;
        end
        default: begin
          led.green <= 1'b0;
          led.amber <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- slsq_top.sv ----
// Purpose: front-panel indicator sequencer with an AXI4-Lite register slave
// Assumes: self-test firmware reports steps and the result through registers
// Notes:   one clock; the second rate is an enable pulse and the blink rate a toggling phase, both from dividers
//
// How it works
// - power lamp lights and self-test starts at the first edge after reset
// - health dark, ring lamp toggles per step
// - unit lamps alternate amber/green, seconds 30-40
// - clean pass lights health green steadily
// - fatal result or 60 s timeout keeps dark
// - ring lamp green when ring up, else off
// - each port drives status and unit lamps
// - port status lamp shows six software-set encodings
// - operational encodings only after self-test ends
`timescale 1ns/1ns
module slsq_top #(
  parameter int unsigned SEC_CYCLES   = slsq_pkg::SEC_CYCLES,
  parameter int unsigned BLINK_CYCLES = slsq_pkg::BLINK_CYCLES
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [7:0]                      s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [7:0]                      s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic                                 irq,
  output logic                                 power_led,
  output logic                                 health_led,
  output logic                                 ring_led,
  output logic [slsq_pkg::NUM_PORTS-1:0]       port_led_green,
  output logic [slsq_pkg::NUM_PORTS-1:0]       port_led_amber,
  output logic [slsq_pkg::NUM_PORTS-1:0]       unit_led_green,
  output logic [slsq_pkg::NUM_PORTS-1:0]       unit_led_amber
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  slsq_pkg::slsq_state_t state_q;
  logic                  power_q;
  logic [24:0]           sec_div_q;
  logic [24:0]           blink_div_q;
  logic                  sec_tick;
  logic                  phase_q;
  logic [6:0]            sec_cnt_q;
  logic                  step_q;
  logic                  lamp_win;
  logic [1:0]            ctrl_q;
  logic [2:0]            irq_stat_q;
  logic [2:0]            irq_mask_q;
  logic [2:0]            irq_set;
  logic                  irq_q;
  logic [8:0]            port_q [slsq_pkg::NUM_PORTS];

  logic                  awready_q;
  logic                  wready_q;
  logic                  aw_hold_q;
  logic                  w_hold_q;
  logic [7:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  do_wr;
  logic                  do_rd;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [31:0]           rd_data;
  logic                  step_wr;
  logic                  result_wr;
  logic                  pass_ev;
  logic                  fail_ev;

  slsq_led_if led_if [slsq_pkg::NUM_LEDS] ();

  // ----------------------------------------------------------------------
  // rate dividers
  // ----------------------------------------------------------------------
  assign sec_tick = (sec_div_q == 25'(SEC_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_div_q <= '0;
    end else if (sec_tick || state_q != slsq_pkg::ST_TEST) begin
      sec_div_q <= '0;
    end else begin
      sec_div_q <= sec_div_q + 25'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_div_q <= '0;
      phase_q     <= 1'b0;
    end else if (blink_div_q == 25'(BLINK_CYCLES - 1)) begin
      blink_div_q <= '0;
      phase_q     <= ~phase_q;
    end else begin
      blink_div_q <= blink_div_q + 25'h1;
    end
  end

  // ----------------------------------------------------------------------
  // power-up sequencer
  // ----------------------------------------------------------------------
  assign step_wr   = do_wr && wr_hit && awaddr_q == slsq_pkg::ADDR_STEP && wstrb_q[0];
  assign result_wr = do_wr && wr_hit && awaddr_q == slsq_pkg::ADDR_RESULT && wstrb_q[0];
  assign pass_ev   = state_q == slsq_pkg::ST_TEST && result_wr && wdata_q[slsq_pkg::RESULT_DONE]
                     && !wdata_q[slsq_pkg::RESULT_FATAL];
  // fatal report or deadline: dark state
  assign fail_ev   = state_q == slsq_pkg::ST_TEST && !pass_ev
                     && ((result_wr && wdata_q[slsq_pkg::RESULT_DONE] && wdata_q[slsq_pkg::RESULT_FATAL])
                     || (sec_tick && sec_cnt_q == slsq_pkg::FAIL_S - 7'h1));
  assign lamp_win  = state_q == slsq_pkg::ST_TEST && sec_cnt_q >= slsq_pkg::LAMP_START_S
                     && sec_cnt_q < slsq_pkg::LAMP_END_S;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= slsq_pkg::ST_POWER;
      power_q <= 1'b0;
    end else begin
      power_q <= 1'b1;
      unique case (state_q)
        slsq_pkg::ST_POWER: state_q <= slsq_pkg::ST_TEST;
        slsq_pkg::ST_TEST: begin
          if (pass_ev) begin
            state_q <= slsq_pkg::ST_RUN;
          end else if (fail_ev) begin
            state_q <= slsq_pkg::ST_FAIL;
          end
        end
        slsq_pkg::ST_RUN, slsq_pkg::ST_FAIL: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_q <= '0;
    end else if (state_q == slsq_pkg::ST_TEST && sec_tick && sec_cnt_q != 7'h7f) begin
      sec_cnt_q <= sec_cnt_q + 7'h1;
    end
  end

  // each step flips the ring lamp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_q <= 1'b0;
    end else if (state_q == slsq_pkg::ST_TEST && step_wr) begin
      step_q <= ~step_q;
    end
  end

  // ----------------------------------------------------------------------
  // indicator modes
  // ----------------------------------------------------------------------
  always_comb begin
    led_if[slsq_pkg::LED_HEALTH].mode = slsq_pkg::MODE_OFF;
    led_if[slsq_pkg::LED_RING].mode   = slsq_pkg::MODE_OFF;
    if (state_q == slsq_pkg::ST_RUN) begin
      led_if[slsq_pkg::LED_HEALTH].mode = ctrl_q[slsq_pkg::CTRL_NONFATAL] ?
        slsq_pkg::MODE_FLASH_G : slsq_pkg::MODE_GREEN;
      led_if[slsq_pkg::LED_RING].mode   = ctrl_q[slsq_pkg::CTRL_RING_OK] ?
        slsq_pkg::MODE_GREEN : slsq_pkg::MODE_OFF;
    end else if (state_q == slsq_pkg::ST_TEST && step_q) begin
      led_if[slsq_pkg::LED_RING].mode   = slsq_pkg::MODE_GREEN;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < slsq_pkg::NUM_PORTS; gi++) begin : g_port
      logic [8:0] pw_mux;

      always_comb begin
        pw_mux = port_q[gi];
        if (wstrb_q[0]) begin
          pw_mux[7:0] = wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          pw_mux[8] = wdata_q[8];
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          port_q[gi] <= '0;
        end else if (do_wr && wr_hit && awaddr_q == slsq_pkg::ADDR_PORT_BASE + 8'(4 * gi)) begin
          port_q[gi] <= pw_mux;
        end
      end

      // two lamps per port, each with its own encoder
      always_comb begin
        led_if[gi].mode = slsq_pkg::MODE_OFF;
        led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_OFF;
        if (state_q == slsq_pkg::ST_RUN) begin
          led_if[gi].mode = slsq_pkg::slsq_mode_t'(port_q[gi][slsq_pkg::PORT_MODE +: 3]);
          if (port_q[gi][slsq_pkg::PORT_FAULT]) begin
            led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_AMBER;
          end else begin
            unique case (slsq_pkg::slsq_unit_t'(port_q[gi][slsq_pkg::PORT_UNIT +: 2]))
              slsq_pkg::UNIT_M:  led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_OFF;
              slsq_pkg::UNIT_S:  led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_GREEN;
              slsq_pkg::UNIT_AB: led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_FLASH_G;
              default:           led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_OFF;
            endcase
          end
        end else if (lamp_win) begin
          led_if[slsq_pkg::NUM_PORTS + gi].mode = slsq_pkg::MODE_ALT;
        end
      end

      assign port_led_green[gi] = led_if[gi].green;
      assign port_led_amber[gi] = led_if[gi].amber;
      assign unit_led_green[gi] = led_if[slsq_pkg::NUM_PORTS + gi].green;
      assign unit_led_amber[gi] = led_if[slsq_pkg::NUM_PORTS + gi].amber;
    end

    for (gi = 0; gi < slsq_pkg::NUM_LEDS; gi++) begin : g_enc
      slsq_led_enc u_enc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .phase   (phase_q),
        .led     (led_if[gi])
      );
    end
  endgenerate

  assign health_led = led_if[slsq_pkg::LED_HEALTH].green;
  assign ring_led   = led_if[slsq_pkg::LED_RING].green;
  assign power_led  = power_q;

  // ----------------------------------------------------------------------
  // control, interrupt status and mask
  // ----------------------------------------------------------------------
  assign irq_set = {state_q == slsq_pkg::ST_TEST && sec_tick && sec_cnt_q == slsq_pkg::LAMP_START_S - 7'h1,
                    fail_ev, pass_ev};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= slsq_pkg::CTRL_RESET;
    end else if (do_wr && wr_hit && awaddr_q == slsq_pkg::ADDR_CTRL && wstrb_q[0]) begin
      ctrl_q <= wdata_q[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= slsq_pkg::IRQ_MASK_RESET;
    end else if (do_wr && wr_hit && awaddr_q == slsq_pkg::ADDR_IRQ_MASK && wstrb_q[0]) begin
      irq_mask_q <= wdata_q[2:0];
    end
  end

  // read clears, but an event in the same cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else if (do_rd && s_axi_araddr == slsq_pkg::ADDR_IRQ_STATUS) begin
      irq_stat_q <= irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------------
  assign do_wr  = aw_hold_q && w_hold_q && !bvalid_q;
  assign do_rd  = s_axi_arvalid && arready_q;
  assign wr_hit = awaddr_q[1:0] == 2'h0 && (awaddr_q <= slsq_pkg::ADDR_IRQ_MASK
                  || (awaddr_q >= slsq_pkg::ADDR_PORT_BASE
                  && awaddr_q < slsq_pkg::ADDR_PORT_BASE + 8'(4 * slsq_pkg::NUM_PORTS)))
                  && awaddr_q != slsq_pkg::ADDR_STATUS && awaddr_q != slsq_pkg::ADDR_IRQ_STATUS;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    unique case (s_axi_araddr)
      slsq_pkg::ADDR_CTRL:       rd_data[1:0] = ctrl_q;
      slsq_pkg::ADDR_STATUS: begin
        rd_data[slsq_pkg::STATUS_STATE +: 2] = state_q;
        rd_data[slsq_pkg::STATUS_SEC +: 7]   = sec_cnt_q;
      end
      slsq_pkg::ADDR_IRQ_STATUS: rd_data[2:0] = irq_stat_q;
      slsq_pkg::ADDR_IRQ_MASK:   rd_data[2:0] = irq_mask_q;
      default: begin
        rd_hit = 1'b0;
        for (int p = 0; p < slsq_pkg::NUM_PORTS; p++) begin
          if (s_axi_araddr == slsq_pkg::ADDR_PORT_BASE + 8'(4 * p)) begin
            rd_hit       = 1'b1;
            rd_data[8:0] = port_q[p];
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      wready_q  <= 1'b1;
      w_hold_q  <= 1'b0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= slsq_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? slsq_pkg::RESP_OKAY : slsq_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= slsq_pkg::RESP_OKAY;
    end else if (do_rd) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_hit ? slsq_pkg::RESP_OKAY : slsq_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

// ---- slsq_sva.sv ----
// Purpose: port-level checks of the indicator sequencer
// Assumes: write address and data are taken at one edge
// Notes:   shadow flops track result and ctrl writes
`timescale 1ns/1ns
module slsq_sva #(
  parameter int unsigned SEC_CYCLES   = 20,
  parameter int unsigned BLINK_CYCLES = 4
) (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic [7:0]                   s_axi_awaddr,
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic [31:0]                  s_axi_wdata,
  input wire logic [3:0]                   s_axi_wstrb,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic                         power_led,
  input wire logic                         health_led,
  input wire logic                         ring_led,
  input wire logic [slsq_pkg::NUM_PORTS-1:0] port_led_green,
  input wire logic [slsq_pkg::NUM_PORTS-1:0] port_led_amber,
  input wire logic [slsq_pkg::NUM_PORTS-1:0] unit_led_green,
  input wire logic [slsq_pkg::NUM_PORTS-1:0] unit_led_amber
);
  localparam int BW = 2 * BLINK_CYCLES + 2;
  localparam int LS = 30 * SEC_CYCLES;
  localparam int TO = 61 * SEC_CYCLES;
  int         cyc_q;
  logic [3:0] st_q;
  logic [1:0] ctrl_q;
  logic       pass_q;
  logic       fail_q;
  wire        wr    = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
  wire        res   = wr & (s_axi_awaddr == slsq_pkg::ADDR_RESULT) & s_axi_wdata[0];
  wire [23:0] lamps = {port_led_green, port_led_amber, unit_led_green, unit_led_amber};
  // st_q restarts on writes to skip lamp lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q  <= 0;
      st_q   <= 4'h0;
      ctrl_q <= 2'h0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      cyc_q <= cyc_q + 1;
      st_q  <= wr ? 4'h0 : st_q + {3'h0, st_q != 4'hf};
      if (wr && s_axi_awaddr == slsq_pkg::ADDR_CTRL) ctrl_q <= s_axi_wdata[1:0];
      if (res && !s_axi_wdata[1] && !fail_q) pass_q <= 1'b1;
      if (res && s_axi_wdata[1] && !pass_q) fail_q <= 1'b1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_power; $past(aresetn) |-> power_led; endproperty
  a_power: assert property (p_power) else $error("power lamp dark");
  property p_dark; !pass_q |-> !health_led; endproperty
  a_dark: assert property (p_dark) else $error("health lit early");
  property p_port; !pass_q |-> (port_led_green | port_led_amber) == '0; endproperty
  a_port: assert property (p_port) else $error("port lamp lit early");
  property p_unit; !pass_q && cyc_q < LS |-> (unit_led_green | unit_led_amber) == '0; endproperty
  a_unit: assert property (p_unit) else $error("unit lamp lit early");
  property p_fail; (fail_q && st_q > 4'h4) || (!pass_q && cyc_q > TO) |-> lamps == '0 && !health_led && !ring_led;
  endproperty
  a_fail: assert property (p_fail) else $error("lamp lit after failure");
  property p_steady; pass_q && st_q > 4'h4 && !ctrl_q[0] |-> health_led; endproperty
  a_steady: assert property (p_steady) else $error("health not steady");
  property p_flash; pass_q && st_q > 4'h4 && ctrl_q[0] |-> ##[1:BW] $changed(health_led); endproperty
  a_flash: assert property (p_flash) else $error("health not flashing");
  property p_ring; pass_q && st_q > 4'h4 |-> ring_led == ctrl_q[1]; endproperty
  a_ring: assert property (p_ring) else $error("ring lamp wrong");
endmodule

bind slsq_top slsq_sva #(.SEC_CYCLES(SEC_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) i_slsq_sva (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .power_led, .health_led, .ring_led, .port_led_green,
  .port_led_amber, .unit_led_green, .unit_led_amber);

// ---- slsq_top_tb.sv ----
// Purpose: directed regression of the indicator sequencer
// Assumes: shortened second and blink counts
// Notes:   bready and rready stay high
`timescale 1ns/1ns
module slsq_top_tb;
  localparam int         SC = 20;
  localparam int         BK = 4;
  localparam logic [1:0] OK = slsq_pkg::RESP_OKAY;
  localparam logic [1:0] SE = slsq_pkg::RESP_SLVERR;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic        power_led, health_led, ring_led;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [slsq_pkg::NUM_PORTS-1:0] port_led_green, port_led_amber, unit_led_green, unit_led_amber;
  wire  [23:0] lamps = {port_led_green, port_led_amber, unit_led_green, unit_led_amber};
  int          n_errors, tests_run, wd;
  slsq_top #(.SEC_CYCLES(SC), .BLINK_CYCLES(BK)) i_slsq_top (.*);

  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, 32'(e), 32'(g));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(e), 32'(s_axi_bresp));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", 32'(r), 32'(s_axi_rresp));
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    cy(20);
    aresetn <= 1'b1;
    cy(1);
  endtask
  task automatic t_init();
    rdc(slsq_pkg::ADDR_STATUS, 32'(slsq_pkg::ST_TEST), 32'h3, OK);
    rdc(slsq_pkg::ADDR_CTRL, 32'(slsq_pkg::CTRL_RESET), '1, OK);
    rdc(slsq_pkg::ADDR_IRQ_MASK, 32'(slsq_pkg::IRQ_MASK_RESET), '1, OK);
    rdc(8'h18, 32'h0, '1, SE);
    wr(slsq_pkg::ADDR_STATUS, 32'h1, SE);
    chb("power", 1'b1, power_led);
    chb("health", 1'b0, health_led);
  endtask
  task automatic t_step();
    logic r;
    for (int i = 0; i < 3; i++) begin
      r = ring_led;
      wr(slsq_pkg::ADDR_STEP, 32'h1, OK);
      cy(3);
      chb("ring step", ~r, ring_led);
    end
  endtask
  task automatic t_lamp();
    logic [5:0] g;
    cy(31 * SC);
    chk("unit lit", 32'h3f, 32'(unit_led_green | unit_led_amber));
    g = unit_led_green;
    cy(BK);
    chk("unit alt", {26'h0, ~g}, {26'h0, unit_led_green});
    chb("irq masked", 1'b0, irq);
    wr(slsq_pkg::ADDR_IRQ_MASK, 32'h7, OK);
    cy(3);
    chb("irq set", 1'b1, irq);
    rdc(slsq_pkg::ADDR_IRQ_STATUS, 32'h4, '1, OK);
    cy(2);
    chb("irq clear", 1'b0, irq);
    cy(9 * SC);
    chk("unit off", 32'h0, 32'(unit_led_green | unit_led_amber));
  endtask
  task automatic t_run();
    logic [31:0] pv [6] = '{32'h000, 32'h011, 32'h022, 32'h033, 32'h114, 32'h005};
    logic [23:0] v;
    wr(slsq_pkg::ADDR_CTRL, 32'h2, OK);
    for (int i = 0; i < 6; i++) wr(slsq_pkg::ADDR_PORT_BASE + 8'(4 * i), pv[i], OK);
    chk("port early", 32'h0, 32'(port_led_green | port_led_amber));
    wr(slsq_pkg::ADDR_RESULT, 32'h1, OK);
    cy(4);
    rdc(slsq_pkg::ADDR_STATUS, 32'(slsq_pkg::ST_RUN), 32'h3, OK);
    rdc(slsq_pkg::ADDR_IRQ_STATUS, 32'h1, '1, OK);
    rdc(slsq_pkg::ADDR_PORT_BASE + 8'h8, 32'h22, '1, OK);
    chb("health on", 1'b1, health_led);
    chb("ring on", 1'b1, ring_led);
    // phase flips every blink period
    v = lamps;
    cy(BK);
    chk("lamps", 32'({6'h02, 6'h04, 6'h02, 6'h10}), 32'(v & ~24'ha30100));
    chk("blink", 32'({6'h28, 6'h30, 6'h04, 6'h00}), 32'(v ^ lamps));
    wr(slsq_pkg::ADDR_CTRL, 32'h3, OK);
    cy(4);
    v[0] = health_led;
    cy(BK);
    chb("health blink", ~v[0], health_led);
    wr(slsq_pkg::ADDR_CTRL, 32'h0, OK);
    cy(4);
    chb("ring off", 1'b0, ring_led);
    chb("health steady", 1'b1, health_led);
  endtask
  task automatic t_fail();
    rst();
    wr(slsq_pkg::ADDR_RESULT, 32'h3, OK);
    wr(slsq_pkg::ADDR_RESULT, 32'h1, OK);
    cy(4);
    rdc(slsq_pkg::ADDR_STATUS, 32'(slsq_pkg::ST_FAIL), 32'h3, OK);
    rdc(slsq_pkg::ADDR_IRQ_STATUS, 32'h2, '1, OK);
    chk("dark", 32'h0, 32'({lamps, health_led, ring_led}));
    rst();
    cy(61 * SC);
    rdc(slsq_pkg::ADDR_STATUS, 32'(slsq_pkg::ST_FAIL), 32'h3, OK);
    rdc(slsq_pkg::ADDR_IRQ_STATUS, 32'h6, '1, OK);
    chb("timeout dark", 1'b0, health_led);
  endtask
  task automatic final_report();
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // run needs ~2200 cycles
  always @(posedge aclk) begin
    wd <= wd + 1;
    if (wd == 6000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    wd = 0;
    n_errors = 0;
    tests_run = 0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    rst();
    t_init();
    t_step();
    t_lamp();
    t_run();
    t_fail();
    final_report();
  end
endmodule
